// File: ahs_defines.vh
// Constants for the arming and hold-off sequencer
`ifndef AHS_DEFINES_VH
`define AHS_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AHS_REG_CTRL 4'h0
`define AHS_REG_ARM_COUNT 4'h1
`define AHS_REG_HOLD_TIME 4'h2
`define AHS_REG_HOLD_COUNT 4'h3
`define AHS_REG_STATUS 4'h4
`define AHS_REG_RESULT 4'h5
// ----------------------------------------
// Control fields
// ----------------------------------------
`define AHS_CTRL_GO 0
`define AHS_CTRL_ARM_EXT 1
`define AHS_CTRL_ARM_EVT 2
`define AHS_CTRL_HOLD_ON 3
`define AHS_CTRL_HOLD_EVT 4
`define AHS_CTRL_STOP_SYNC 5
`define AHS_CTRL_SHARED 6
`define AHS_CTRL_SLOPE_A 7
`define AHS_CTRL_SLOPE_B 8
`define AHS_CTRL_WIDTH 9
`define AHS_CTRL_RESET 9'h000
// ----------------------------------------
// Counts
// ----------------------------------------
`define AHS_EVT_MIN 24'h000002
`define AHS_EVT_OFF 24'h000001
`define AHS_EVT_ZERO 24'h000000
`endif

// File: ahs_edge_detect.v
// Slope-selectable edge detector for one trigger input
module ahs_edge_detect (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire sig,
    input wire rising,
    output wire hit
);
    reg prev;
    always @(posedge clk) begin
        if (srst) begin
            // Seeded from the pin so an idle-high input gives no edge after reset
            prev <= sig;
        end else if (ce) begin
            prev <= sig;
        end
    end
    assign hit = ce & (rising ? (sig & ~prev) : (~sig & prev));
endmodule

// File: ahs_sequencer.v
// Arming and stop hold-off sequencer for a time-interval counter
`include "ahs_defines.vh"
module ahs_sequencer #(
    parameter CNT_W = 24,
    parameter HOLD_W = 32,
    parameter RES_W = 32
) (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire in_a,
    input wire in_b,
    input wire in_e,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    output reg gate,
    output reg armed,
    output reg done
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_WAIT_E = 3'h1;
    localparam [2:0] ST_ARM_CNT = 3'h2;
    localparam [2:0] ST_ARMED = 3'h3;
    localparam [2:0] ST_RUN = 3'h4;
    localparam [2:0] ST_DONE = 3'h5;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [`AHS_CTRL_WIDTH-1:0] ctrl;
    reg [CNT_W-1:0] arm_count;
    reg [HOLD_W-1:0] hold_time;
    reg [CNT_W-1:0] hold_count;
    reg [2:0] state;
    reg [CNT_W-1:0] evt_cnt;
    reg [HOLD_W-1:0] hold_cnt;
    reg hold_busy;
    reg sync_seen;
    reg [RES_W-1:0] result;
    reg bad_combo;

    wire b_src;
    wire hit_a;
    wire hit_b;
    wire e_rise;
    wire e_fall;
    wire go_wr;
    wire arm_evt_on;
    wire hold_evt_on;
    wire stop_ok;
    wire hold_first;
    wire [CNT_W-1:0] hold_left;

    // ----------------------------------------
    // Decode functions
    // ----------------------------------------
    // Delay count of one or below minimum reads as disabled
    function evt_enabled;
        input [CNT_W-1:0] n;
        begin
            evt_enabled = (n >= `AHS_EVT_MIN);
        end
    endfunction

    // Time-armed start would share channel B with an event hold-off
    function combo_refused;
        input [`AHS_CTRL_WIDTH-1:0] c;
        begin
            combo_refused = c[`AHS_CTRL_HOLD_EVT] & c[`AHS_CTRL_HOLD_ON] &
                c[`AHS_CTRL_ARM_EXT] & ~c[`AHS_CTRL_ARM_EVT];
        end
    endfunction

    // ----------------------------------------
    // Derived controls
    // ----------------------------------------
    assign b_src = ctrl[`AHS_CTRL_SHARED] ? in_a : in_b;
    assign arm_evt_on = ctrl[`AHS_CTRL_ARM_EVT] & evt_enabled(arm_count);
    assign hold_evt_on = ctrl[`AHS_CTRL_HOLD_ON] & ctrl[`AHS_CTRL_HOLD_EVT];
    assign go_wr = wr & (addr == `AHS_REG_CTRL) & wdata[`AHS_CTRL_GO];
    // A B event coincident with the start trigger is the first held one
    assign hold_first = hit_b & (hold_count != `AHS_EVT_ZERO);
    assign hold_left = hold_count - {{(CNT_W-1){1'b0}}, hold_first};

    // ----------------------------------------
    // Trigger edges
    // ----------------------------------------
    ahs_edge_detect u_edge_a (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .sig(in_a),
        .rising(ctrl[`AHS_CTRL_SLOPE_A]),
        .hit(hit_a)
    );

    ahs_edge_detect u_edge_b (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .sig(b_src),
        .rising(ctrl[`AHS_CTRL_SLOPE_B]),
        .hit(hit_b)
    );

    // Sync edges share the detector so reset seeds them the same way
    ahs_edge_detect u_edge_e_rise (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .sig(in_e),
        .rising(1'b1),
        .hit(e_rise)
    );

    ahs_edge_detect u_edge_e_fall (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .sig(in_e),
        .rising(1'b0),
        .hit(e_fall)
    );

    // ----------------------------------------
    // Stop acceptance
    // ----------------------------------------
    // Hold-off and sync gating combine
    assign stop_ok = hit_b & ~hold_busy &
        (~ctrl[`AHS_CTRL_STOP_SYNC] | sync_seen);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            ctrl <= `AHS_CTRL_RESET;
            arm_count <= `AHS_EVT_ZERO;
            hold_time <= {HOLD_W{1'b0}};
            hold_count <= `AHS_EVT_ZERO;
        end else if (ce && wr) begin
            case (addr)
                `AHS_REG_CTRL: ctrl <= wdata[`AHS_CTRL_WIDTH-1:0];
                `AHS_REG_ARM_COUNT: arm_count <= wdata[CNT_W-1:0];
                `AHS_REG_HOLD_TIME: hold_time <= wdata[HOLD_W-1:0];
                `AHS_REG_HOLD_COUNT: hold_count <= wdata[CNT_W-1:0];
                default: ctrl <= ctrl;
            endcase
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            rdata <= 32'h00000000;
        end else if (ce) begin
            if (rd) begin
                case (addr)
                    `AHS_REG_CTRL: rdata <= {{(32-`AHS_CTRL_WIDTH){1'b0}}, ctrl};
                    `AHS_REG_ARM_COUNT: rdata <= {{(32-CNT_W){1'b0}}, arm_count};
                    `AHS_REG_HOLD_TIME: rdata <= hold_time;
                    `AHS_REG_HOLD_COUNT: rdata <= {{(32-CNT_W){1'b0}}, hold_count};
                    `AHS_REG_STATUS: rdata <= {25'h0000000, bad_combo, hold_busy,
                        done, armed, state};
                    `AHS_REG_RESULT: rdata <= result;
                    default: rdata <= 32'h00000000;
                endcase
            end else begin
                rdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            evt_cnt <= `AHS_EVT_ZERO;
            hold_cnt <= {HOLD_W{1'b0}};
            hold_busy <= 1'b0;
            sync_seen <= 1'b0;
            result <= {RES_W{1'b0}};
            bad_combo <= 1'b0;
            gate <= 1'b0;
            armed <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            if (e_fall) begin
                sync_seen <= 1'b1;
            end
            case (state)
                ST_IDLE: begin
                    if (go_wr) begin
                        done <= 1'b0;
                        // A sync trailing edge in the GO cycle still counts
                        sync_seen <= e_fall;
                        // Time delay lives outside; only event arming exists here
                        if (combo_refused(wdata[`AHS_CTRL_WIDTH-1:0])) begin
                            bad_combo <= 1'b1;
                        end else begin
                            bad_combo <= 1'b0;
                            if (wdata[`AHS_CTRL_ARM_EXT]) begin
                                state <= ST_WAIT_E;
                            end else if (wdata[`AHS_CTRL_ARM_EVT] & evt_enabled(arm_count)) begin
                                // Without sync the event delay counts from GO
                                evt_cnt <= arm_count;
                                state <= ST_ARM_CNT;
                            end else begin
                                armed <= 1'b1;
                                state <= ST_ARMED;
                            end
                        end
                    end
                end
                ST_WAIT_E: begin
                    if (e_rise) begin
                        if (arm_evt_on) begin
                            evt_cnt <= arm_count;
                            state <= ST_ARM_CNT;
                        end else begin
                            armed <= 1'b1;
                            state <= ST_ARMED;
                        end
                    end
                end
                ST_ARM_CNT: begin
                    if (hit_b) begin
                        evt_cnt <= evt_cnt - 1'b1;
                        // Count of one left means this event is the Nth
                        if (evt_cnt == `AHS_EVT_OFF) begin
                            armed <= 1'b1;
                            state <= ST_ARMED;
                        end
                    end
                end
                ST_ARMED: begin
                    if (hit_a) begin
                        gate <= 1'b1;
                        result <= {RES_W{1'b0}};
                        state <= ST_RUN;
                        // Hold-off counted from the start trigger itself
                        if (ctrl[`AHS_CTRL_HOLD_ON]) begin
                            hold_busy <= hold_evt_on ? (hold_left != `AHS_EVT_ZERO) :
                                (hold_time != {HOLD_W{1'b0}});
                            hold_cnt <= hold_evt_on ? {{(HOLD_W-CNT_W){1'b0}}, hold_left} :
                                hold_time;
                        end
                    end
                end
                ST_RUN: begin
                    result <= result + 1'b1;
                    // Time mode counts cycles, event mode counts B triggers
                    if (hold_busy) begin
                        if (!hold_evt_on || hit_b) begin
                            hold_cnt <= hold_cnt - 1'b1;
                            if (hold_cnt == {{(HOLD_W-1){1'b0}}, 1'b1}) begin
                                hold_busy <= 1'b0;
                            end
                        end
                    end
                    if (stop_ok) begin
                        gate <= 1'b0;
                        armed <= 1'b0;
                        done <= 1'b1;
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // One quiet cycle before a GO is looked at again
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// File: ahs_checker.sv
// Port assertions for the arming and hold-off sequencer
module ahs_checker (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire in_a,
    input wire in_b,
    input wire in_e,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire gate,
    input wire armed,
    input wire done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ----
    // Assertions; edge timing allowed one cycle of slack
    // ----
    a_gate_armed: assert property (gate |-> armed)
        else $error("gate high while not armed");
    a_gate_start: assert property ($rose(gate) |-> $past(armed)
        && (($past(in_a) && !$past(in_a, 2)) || ($past(in_a, 2) && !$past(in_a, 3))))
        else $error("gate opened without an A edge");
    a_stop_edge: assert property ($fell(gate) |->
        ($past(in_a) && !$past(in_a, 2)) || ($past(in_a, 2) && !$past(in_a, 3)))
        else $error("gate closed without a routed edge");
    a_stop_done: assert property ($fell(gate) |-> done)
        else $error("done missing at stop");
    a_done_sticky: assert property (done && !(wr && addr == 4'h0 && wdata[0]) |=> done)
        else $error("done dropped without a new start");
    a_gate_no_done: assert property (gate |-> !done)
        else $error("done while gate open");
    a_refuse_combo: assert property (wr && addr == 4'h0 && wdata[4:0] == 5'h1B
        && !armed |=> !armed && !gate)
        else $error("forbidden combination started");
    a_go_arms: assert property (wr && addr == 4'h0 && wdata[0] && !wdata[1]
        && !wdata[2] && !armed && !gate |=> armed)
        else $error("start without arming did not arm");
    c_arm: cover property ($rose(armed));
    c_open: cover property ($rose(gate));
    c_close: cover property ($fell(gate));
endmodule

bind ahs_sequencer ahs_checker u_chk (.clk(clk), .srst(srst), .ce(ce), .in_a(in_a),
    .in_b(in_b), .in_e(in_e), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .gate(gate), .armed(armed), .done(done));

// File: ahs_partner.sv
// Burst and sync source model
module ahs_partner (
    input wire clk,
    output logic in_a,
    output logic in_b,
    output logic in_e
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        in_a = 1'b0;
        in_b = 1'b0;
        in_e = 1'b0;
    end
    // Unrouted B wire never steady, so a leak shows
    always @(posedge clk) begin
        in_b <= ~in_b;
    end
    // Pulses at 0, 8, 20, 36, 56: unequal gaps name the pair measured
    task automatic burst(input int lead, input int fall);
        int s;
        int g;
        logic h;
        for (int t = -8; t < 70; t++) begin
            @(posedge clk);
            s = 0;
            g = 8;
            h = 1'b0;
            for (int i = 0; i < 5; i++) begin
                h = h | (t >= s && t < s + 3);
                s = s + g;
                g = g + 4;
            end
            in_a <= h;
            in_e <= (t >= -lead && t < fall);
        end
    endtask
endmodule

// File: ahs_sequencer_tb.sv
// Register-level testbench for the arming and hold-off sequencer
`include "ahs_defines.vh"
module ahs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, ce, wr, rd, gate, armed, done, in_a, in_b, in_e;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, v;
    int fail_count = 0;
    int tests_run = 0;
    localparam logic [31:0] BASE = 32'h1C1;
    ahs_sequencer DUT (.clk(clk), .srst(srst), .ce(ce), .in_a(in_a), .in_b(in_b),
        .in_e(in_e), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .gate(gate), .armed(armed), .done(done));
    ahs_partner far (.clk(clk), .in_a(in_a), .in_b(in_b), .in_e(in_e));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ----
    // Tasks
    // ----
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // One measurement; result is gate length in cycles
    task run(input logic [31:0] ctrl, arm, hcnt, htime, input int lead, fall,
             input logic [31:0] exp);
        wr_reg(`AHS_REG_ARM_COUNT, arm);
        wr_reg(`AHS_REG_HOLD_TIME, htime);
        wr_reg(`AHS_REG_HOLD_COUNT, hcnt);
        wr_reg(`AHS_REG_CTRL, ctrl | BASE);
        far.burst(lead, fall);
        check({31'h0, done}, 32'h1);
        rd_reg(`AHS_REG_RESULT, v);
        check(v, exp);
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        #1 check({29'h0, gate, armed, done}, 32'h0);
        rd_reg(4'hF, v);
        check(v, 32'h0);
        // Hold by events with externally armed start is refused
        wr_reg(`AHS_REG_CTRL, BASE | 32'h1A);
        far.burst(4, 40);
        check({30'h0, armed, done}, 32'h0);
        rd_reg(`AHS_REG_STATUS, v);
        check(v, 32'h00000040);
        wr_reg(`AHS_REG_ARM_COUNT, 32'h00FFFFFF);
        rd_reg(`AHS_REG_ARM_COUNT, v);
        check(v, 32'h00FFFFFF);
        // Frozen clock enable must swallow a write
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(`AHS_REG_ARM_COUNT, 32'h00000002);
        ce <= 1'b1;
        rd_reg(`AHS_REG_ARM_COUNT, v);
        check(v, 32'h00FFFFFF);
        run(32'h0, 32'h0, 32'h0, 32'h0, 0, 0, 32'h8);
        run(32'h18, 32'h0, 32'h3, 32'h0, 0, 0, 32'h24);
        run(32'h08, 32'h0, 32'h0, 32'h19, 0, 0, 32'h24);
        run(32'h06, 32'h2, 32'h0, 32'h0, 4, 2, 32'h10);
        run(32'h06, 32'h1, 32'h0, 32'h0, 4, 2, 32'h8);
        run(32'h04, 32'h2, 32'h0, 32'h0, 0, 0, 32'h10);
        run(32'h20, 32'h0, 32'h0, 32'h0, 4, 28, 32'h24);
        wrap_up;
    end
    // Hang guard
    initial begin
        #100us;
        fail_count++;
        wrap_up;
    end
endmodule
